/* File: src/hvm_pkg.sv */
package hvm_pkg;

    // ------------------------------------------------------------
    // Register map (word index on the plain register port)
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  REG_MEAS_CTRL   = 4'h0;  // Measurement enable
    localparam logic [3:0]  REG_PULL_CFG    = 4'h1;  // Sense pull selection
    localparam logic [3:0]  REG_WAKE_SRC    = 4'h2;  // Wake source enables
    localparam logic [3:0]  REG_AUX_CFG     = 4'h3;  // Aux pin function
    localparam logic [3:0]  REG_FAIL_TEST   = 4'h4;  // Fail output test
    localparam logic [3:0]  REG_WAKE_STAT_A = 4'h5;  // Sense wake flags
    localparam logic [3:0]  REG_WAKE_STAT_B = 4'h6;  // Aux wake flags
    localparam logic [3:0]  REG_WAKE_LVL    = 4'h7;  // Pin levels
    localparam logic [3:0]  REG_FAULT       = 4'h8;  // Configuration fault
    localparam logic [3:0]  REG_STATUS      = 4'h9;  // Path state

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          BIT_SENSE_WAKE  = 0;     // Wake source: sense pin
    localparam int          BIT_AUX_WAKE    = 1;     // Wake source: aux pin
    localparam int          BIT_TIMER_WAKE  = 2;     // Wake source: timer
    localparam int          WAKE_SRC_W      = 3;
    localparam int          AUX_FN_W        = 3;
    localparam int          BIT_AUX_DRIVE   = 3;     // Aux switch on
    localparam logic [7:0]  RST_ZERO        = 8'h00;
    localparam logic [2:0]  RST_WAKE_SRC    = 3'h1;  // Sense wake enabled

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
    } hvm_mode_t;

    typedef enum logic [1:0] {
        PULL_NONE, PULL_DOWN, PULL_UP, PULL_AUTO
    } hvm_pull_t;

    typedef enum logic [2:0] {
        AUX_OFF, AUX_FAIL_OUT, AUX_WAKE_IN, AUX_LOW_SIDE, AUX_HIGH_SIDE
    } hvm_aux_fn_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic pull_up;    // Pull-up source on
        logic pull_down;  // Pull-down source on
    } hvm_pull_t_pair_t;

    typedef struct packed {
        logic out;        // Driven level
        logic oe;         // High while driving
    } hvm_pin_drv_t;

endpackage

/* File: src/hvm_route_ctrl.sv */
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
module hvm_route_ctrl (
    // Clock, reset, enable
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    input  wire logic                     clk_en,
    // Register port
    input  wire logic [hvm_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [hvm_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [hvm_pkg::DATA_W-1:0] reg_rdata,
    // Device state
    input  wire hvm_pkg::hvm_mode_t       op_mode,
    input  wire logic                     sleep_cmd,
    input  wire logic                     fail_active,
    // Sense pin
    input  wire logic                     hv_sense_pin,
    output hvm_pkg::hvm_pull_t_pair_t     sense_pull,
    // Aux pin
    input  wire logic                     fail_aux_pin_in,
    output logic                          fail_aux_pin_out,
    output logic                          fail_aux_pin_oe,
    output hvm_pkg::hvm_pull_t_pair_t     aux_pull,
    // Measurement switch and events
    output logic                          meas_switch_close,
    output logic                          restart_req,
    output logic                          sleep_ok,
    output logic                          wake_event
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                            measure_path_enable_q;  // Measurement enable
    hvm_pkg::hvm_pull_t              sense_pull_config_q;    // Pull selection
    logic [hvm_pkg::WAKE_SRC_W-1:0]  wake_source_ctrl_b_q;   // Wake source enables
    hvm_pkg::hvm_aux_fn_t            aux_fn_q;               // Aux pin function
    logic                            aux_drive_q;            // Aux switch on
    logic                            fail_out_test_on_q;     // Fail output test
    logic [1:0]                      wake_status_a_q;        // Sense rise/fall
    logic [1:0]                      wake_status_b_q;        // Aux rise/fall
    logic [1:0]                      wake_level_status_q;    // Sense, aux levels
    logic                            cfg_fault_q;            // Configuration fault
    logic [1:0]                      sense_sync_q;           // Sense synchroniser
    logic [1:0]                      aux_sync_q;             // Aux synchroniser
    logic                            sense_prev_q;           // Last sense level
    logic                            aux_prev_q;             // Last aux level
    logic [hvm_pkg::DATA_W-1:0]      rdata_q;                // Read data
    logic                            restart_q;              // Restart pulse
    logic                            sleep_ok_q;             // Sleep accepted pulse
    logic                            wake_q;                 // Wake pulse
    logic                            measuring;              // Enable in force
    logic                            wr_meas;                // Write to enable
    logic                            wr_aux;                 // Write to aux config
    logic                            enable_refused;         // Enable write refused
    logic                            aux_change_bad;         // Aux change while measuring
    logic                            sleep_fault;            // Sleep with pin wakes only
    logic                            sense_rise;             // Sense rising edge
    logic                            sense_fall;             // Sense falling edge
    logic                            aux_rise;               // Aux rising edge
    logic                            aux_fall;               // Aux falling edge
    logic                            sense_wake_on;          // Sense wake effective
    logic                            aux_wake_on;            // Aux wake effective
    logic [1:0]                      clr_a;                  // Write-one clears
    logic [1:0]                      clr_b;
    logic                            clr_fault;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Write strobe decode for one register
    function automatic logic wr_hit(input logic [hvm_pkg::ADDR_W-1:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    // Pull sources for one pin from a selection and level
    function automatic hvm_pkg::hvm_pull_t_pair_t pull_of(
        input hvm_pkg::hvm_pull_t sel,
        input logic               lvl
    );
        hvm_pkg::hvm_pull_t_pair_t p;
        p = '{pull_up: 1'b0, pull_down: 1'b0};
        unique case (sel)
            hvm_pkg::PULL_NONE: p = '{pull_up: 1'b0, pull_down: 1'b0};
            hvm_pkg::PULL_DOWN: p = '{pull_up: 1'b0, pull_down: 1'b1};
            hvm_pkg::PULL_UP:   p = '{pull_up: 1'b1, pull_down: 1'b0};
            hvm_pkg::PULL_AUTO: p = '{pull_up: lvl, pull_down: ~lvl};
        endcase
        return p;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Enable bit in force
    assign measuring = measure_path_enable_q;
    assign wr_meas   = wr_hit(hvm_pkg::REG_MEAS_CTRL);
    assign wr_aux    = wr_hit(hvm_pkg::REG_AUX_CFG);
    // Enable request while aux pin not off
    assign enable_refused = wr_meas && reg_wdata[0] && !measuring
                            && (aux_fn_q != hvm_pkg::AUX_OFF);
    // Any change of the aux setup while measuring
    assign aux_change_bad = wr_aux && measuring
                            && (reg_wdata[hvm_pkg::AUX_FN_W-1:0] != aux_fn_q
                                || reg_wdata[hvm_pkg::BIT_AUX_DRIVE] != aux_drive_q);
    // Wake enables only count when not measuring
    assign sense_wake_on = wake_source_ctrl_b_q[hvm_pkg::BIT_SENSE_WAKE] && !measuring;
    assign aux_wake_on   = (aux_fn_q == hvm_pkg::AUX_WAKE_IN)
                           && wake_source_ctrl_b_q[hvm_pkg::BIT_AUX_WAKE] && !measuring;
    // Sleep while measuring with only pin wake sources
    assign sleep_fault = sleep_cmd && measuring
                         && !wake_source_ctrl_b_q[hvm_pkg::BIT_TIMER_WAKE]
                         && (wake_source_ctrl_b_q[hvm_pkg::BIT_SENSE_WAKE]
                             || (aux_fn_q == hvm_pkg::AUX_WAKE_IN
                                 && wake_source_ctrl_b_q[hvm_pkg::BIT_AUX_WAKE]));
    // Write-one clear masks
    assign clr_a     = wr_hit(hvm_pkg::REG_WAKE_STAT_A) ? reg_wdata[1:0] : 2'h0;
    assign clr_b     = wr_hit(hvm_pkg::REG_WAKE_STAT_B) ? reg_wdata[1:0] : 2'h0;
    assign clr_fault = wr_hit(hvm_pkg::REG_FAULT) && reg_wdata[0];
    // Edges against last level
    assign sense_rise = sense_sync_q[1] && !sense_prev_q;
    assign sense_fall = !sense_sync_q[1] && sense_prev_q;
    assign aux_rise   = aux_sync_q[1] && !aux_prev_q;
    assign aux_fall   = !aux_sync_q[1] && aux_prev_q;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two stages per pin, second stage feeds logic
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sense_sync_q <= 2'h0;
            aux_sync_q   <= 2'h0;
            sense_prev_q <= 1'b0;
            aux_prev_q   <= 1'b0;
        end else if (clk_en) begin
            // Shift pins in
            sense_sync_q <= {sense_sync_q[0], hv_sense_pin};
            aux_sync_q   <= {aux_sync_q[0], fail_aux_pin_in};
            sense_prev_q <= sense_sync_q[1];
            aux_prev_q   <= aux_sync_q[1];
        end
    end

    // ------------------------------------------------------------
    // Measurement enable
    // ------------------------------------------------------------
    // Cleared at reset; refused requests leave it clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            measure_path_enable_q <= 1'b0;
        // Refused write keeps old value
        end else if (clk_en && wr_meas && !enable_refused) begin
            measure_path_enable_q <= reg_wdata[0];
        end
    end

    // ------------------------------------------------------------
    // Pin configuration registers
    // ------------------------------------------------------------
    // Stored even while measuring, just not applied
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Sense wake only, aux off
            sense_pull_config_q  <= hvm_pkg::PULL_NONE;
            wake_source_ctrl_b_q <= hvm_pkg::RST_WAKE_SRC;
            aux_fn_q             <= hvm_pkg::AUX_OFF;
            aux_drive_q          <= 1'b0;
            fail_out_test_on_q   <= 1'b0;
        end else if (clk_en) begin
            if (wr_hit(hvm_pkg::REG_PULL_CFG)) begin
                sense_pull_config_q <= hvm_pkg::hvm_pull_t'(reg_wdata[1:0]);
            end
            if (wr_hit(hvm_pkg::REG_WAKE_SRC)) begin
                wake_source_ctrl_b_q <= reg_wdata[hvm_pkg::WAKE_SRC_W-1:0];
            end
            if (wr_aux) begin
                aux_fn_q    <= hvm_pkg::hvm_aux_fn_t'(reg_wdata[hvm_pkg::AUX_FN_W-1:0]);
                aux_drive_q <= reg_wdata[hvm_pkg::BIT_AUX_DRIVE];
            end
            if (wr_hit(hvm_pkg::REG_FAIL_TEST)) begin
                fail_out_test_on_q <= reg_wdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Wake and level status
    // ------------------------------------------------------------
    // Pin events update status only when not measuring; set wins
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_status_a_q     <= 2'h0;
            wake_status_b_q     <= 2'h0;
            wake_level_status_q <= 2'h0;
        end else if (clk_en) begin
            wake_status_a_q <= (wake_status_a_q & ~clr_a)
                               | ({sense_fall, sense_rise} & {2{sense_wake_on}});
            wake_status_b_q <= (wake_status_b_q & ~clr_b)
                               | ({aux_fall, aux_rise} & {2{aux_wake_on}});
            // Levels frozen while measuring
            if (!measuring) begin
                wake_level_status_q <= {aux_sync_q[1], sense_sync_q[1]};
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration fault flag
    // ------------------------------------------------------------
    // Any illegal attempt sets it; set beats a clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_fault_q <= 1'b0;
        end else if (clk_en) begin
            // Set beats clear
            if (enable_refused || aux_change_bad || sleep_fault) begin
                cfg_fault_q <= 1'b1;
            end else if (clr_fault) begin
                cfg_fault_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Event pulses
    // ------------------------------------------------------------
    // Sleep outcome and wake indication, one cycle each
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            restart_q  <= 1'b0;
            sleep_ok_q <= 1'b0;
            wake_q     <= 1'b0;
        end else if (clk_en) begin
            // Faulted sleep restarts
            restart_q  <= sleep_fault;
            sleep_ok_q <= sleep_cmd && !sleep_fault;
            wake_q     <= (sense_wake_on && (sense_rise || sense_fall))
                          || (aux_wake_on && (aux_rise || aux_fall));
        end
    end

    // Registered pulses out
    assign restart_req = restart_q;
    assign sleep_ok    = sleep_ok_q;
    assign wake_event  = wake_q;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Data stands in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= hvm_pkg::RST_ZERO;
        end else if (clk_en) begin
            // Zero unless strobed
            rdata_q <= hvm_pkg::RST_ZERO;
            if (reg_rd) begin
                unique case (reg_addr)
                    hvm_pkg::REG_MEAS_CTRL:   rdata_q[0] <= measure_path_enable_q;
                    hvm_pkg::REG_PULL_CFG:    rdata_q[1:0] <= sense_pull_config_q;
                    hvm_pkg::REG_WAKE_SRC:
                        rdata_q[hvm_pkg::WAKE_SRC_W-1:0] <= wake_source_ctrl_b_q;
                    hvm_pkg::REG_AUX_CFG: begin
                        rdata_q[hvm_pkg::AUX_FN_W-1:0]   <= aux_fn_q;
                        rdata_q[hvm_pkg::BIT_AUX_DRIVE]  <= aux_drive_q;
                    end
                    hvm_pkg::REG_FAIL_TEST:   rdata_q[0] <= fail_out_test_on_q;
                    hvm_pkg::REG_WAKE_STAT_A: rdata_q[1:0] <= wake_status_a_q;
                    hvm_pkg::REG_WAKE_STAT_B: rdata_q[1:0] <= wake_status_b_q;
                    hvm_pkg::REG_WAKE_LVL:    rdata_q[1:0] <= wake_level_status_q;
                    hvm_pkg::REG_FAULT:       rdata_q[0] <= cfg_fault_q;
                    hvm_pkg::REG_STATUS:      rdata_q[1:0] <= {measuring, meas_switch_close};
                    default:                  rdata_q <= hvm_pkg::RST_ZERO;
                endcase
            end
        end
    end

    // Registered read data
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Switch, pulls and aux driver
    // ------------------------------------------------------------
    // Switch closes only in normal mode; setting survives other modes
    assign meas_switch_close = measuring && (op_mode == hvm_pkg::MODE_NORMAL);

    // Pull sources off on both pins while measuring
    always_comb begin
        sense_pull = pull_of(sense_pull_config_q, sense_sync_q[1]);
        aux_pull   = '{pull_up: 1'b0, pull_down: 1'b0};
        // Aux pulls only as wake input
        if (aux_fn_q == hvm_pkg::AUX_WAKE_IN) begin
            aux_pull = pull_of(sense_pull_config_q, aux_sync_q[1]);
        end
        if (measuring) begin
            sense_pull = '{pull_up: 1'b0, pull_down: 1'b0};
            aux_pull   = '{pull_up: 1'b0, pull_down: 1'b0};
        end
    end

    // Aux function drive, released entirely while measuring
    always_comb begin
        fail_aux_pin_out = 1'b0;
        fail_aux_pin_oe  = 1'b0;
        if (!measuring) begin
            unique case (aux_fn_q)
                hvm_pkg::AUX_FAIL_OUT: begin
                    // Low on fail or test
                    fail_aux_pin_oe = fail_active || fail_out_test_on_q;
                end
                hvm_pkg::AUX_LOW_SIDE: begin
                    // Sinks when on
                    fail_aux_pin_oe = aux_drive_q;
                end
                hvm_pkg::AUX_HIGH_SIDE: begin
                    // Sources when on
                    fail_aux_pin_out = 1'b1;
                    fail_aux_pin_oe  = aux_drive_q;
                end
                default: begin
                    // Pin left free
                    fail_aux_pin_oe = 1'b0;
                end
            endcase
        end
    end

endmodule

/* File: test/hvm_route_checker.sv */
`timescale 1ns/1ps
module hvm_route_checker (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst_b,
    input  wire logic                         clk_en,
    // Register port
    input  wire logic                         reg_wr,
    // Device state
    input  wire hvm_pkg::hvm_mode_t           op_mode,
    input  wire logic                         sleep_cmd,
    // Pin side and events
    input  wire hvm_pkg::hvm_pull_t_pair_t    sense_pull,
    input  wire hvm_pkg::hvm_pull_t_pair_t    aux_pull,
    input  wire logic                         fail_aux_pin_oe,
    input  wire logic                         meas_switch_close,
    input  wire logic                         restart_req,
    input  wire logic                         sleep_ok,
    input  wire logic                         wake_event
);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence meas_held;
        meas_switch_close [*4];
    endsequence
    sequence sleep_taken;
        sleep_cmd && clk_en;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_close_normal:
        assert property (meas_switch_close |-> op_mode == hvm_pkg::MODE_NORMAL)
        else $error("Switch closed outside normal mode");
    chk_sense_pulls:
        assert property (meas_switch_close |-> sense_pull == 2'h0)
        else $error("Sense pull active while measuring");
    chk_aux_pulls:
        assert property (meas_switch_close |-> aux_pull == 2'h0)
        else $error("Aux pull active while measuring");
    chk_aux_quiet:
        assert property (meas_switch_close |-> !fail_aux_pin_oe)
        else $error("Aux pin driven while measuring");
    chk_wake_frozen:
        assert property (meas_held |-> !wake_event)
        else $error("Wake event while measuring");
    chk_sleep_answer:
        assert property (sleep_taken |=> restart_req ^ sleep_ok)
        else $error("Sleep command without single answer");
    chk_answer_cause:
        assert property ((restart_req || sleep_ok) |-> $past(sleep_cmd) && $past(clk_en))
        else $error("Sleep answer without command");
    chk_switch_kept:
        assert property (meas_switch_close && !reg_wr |=>
                         meas_switch_close || op_mode != hvm_pkg::MODE_NORMAL)
        else $error("Switch opened without write");
endmodule
bind hvm_route_ctrl hvm_route_checker u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_wr(reg_wr),
    .op_mode(op_mode), .sleep_cmd(sleep_cmd), .sense_pull(sense_pull),
    .aux_pull(aux_pull), .fail_aux_pin_oe(fail_aux_pin_oe),
    .meas_switch_close(meas_switch_close), .restart_req(restart_req),
    .sleep_ok(sleep_ok), .wake_event(wake_event));

/* File: test/hvm_adc_model.sv */
`timescale 1ns/1ps
module hvm_adc_model (
    // Clock
    input  wire logic core_clk,
    // Pin side
    input  wire logic switch_close,
    input  wire logic sense_level,
    input  wire logic aux_out,
    input  wire logic aux_oe,
    input  wire hvm_pkg::hvm_pull_t_pair_t aux_pull,
    output logic      aux_wire,
    output logic      adc_level
);
    logic flip_q = 1'b0; // Pattern on an undriven pin
    // Floating pin never holds a stale level
    always_ff @(posedge core_clk) begin
        flip_q <= ~flip_q;
    end
    // Closed switch carries the sense pin, else driver, else pull source, else floating
    always_comb begin
        if (switch_close) begin
            aux_wire = sense_level;
        end else if (aux_oe) begin
            aux_wire = aux_out;
        end else if (aux_pull.pull_up) begin
            aux_wire = 1'b1;
        end else if (aux_pull.pull_down) begin
            aux_wire = 1'b0;
        end else begin
            aux_wire = flip_q;
        end
    end
    // Converter samples the divided pin each cycle
    always_ff @(posedge core_clk) begin
        adc_level <= aux_wire;
    end
endmodule

/* File: test/tb_hvm_route_ctrl.sv */
`timescale 1ns/1ps
module tb_hvm_route_ctrl;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk, rst_b, clk_en, reg_wr, reg_rd, sleep_cmd, fail_active, sense;
    logic aux_in, aux_out, aux_oe, sw, restart_req, sleep_ok, wake_event, adc;
    logic [3:0]                 reg_addr;
    logic [7:0]                 reg_wdata, reg_rdata;
    hvm_pkg::hvm_mode_t         op_mode;
    hvm_pkg::hvm_pull_t_pair_t  sense_pull, aux_pull;
    int                         num_errors = 0, total_checks = 0;
    hvm_route_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .op_mode(op_mode), .sleep_cmd(sleep_cmd),
        .fail_active(fail_active), .hv_sense_pin(sense), .sense_pull(sense_pull),
        .fail_aux_pin_in(aux_in), .fail_aux_pin_out(aux_out), .fail_aux_pin_oe(aux_oe),
        .aux_pull(aux_pull), .meas_switch_close(sw), .restart_req(restart_req),
        .sleep_ok(sleep_ok), .wake_event(wake_event));
    hvm_adc_model u_adc (.core_clk(core_clk), .switch_close(sw), .sense_level(sense),
        .aux_out(aux_out), .aux_oe(aux_oe), .aux_pull(aux_pull), .aux_wire(aux_in),
        .adc_level(adc));
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask
    task automatic sleep_try(input logic e_restart, input logic e_ok);
        @(posedge core_clk);
        sleep_cmd <= 1'b1;
        @(posedge core_clk);
        sleep_cmd <= 1'b0;
        #1 chk("restart", 8'(restart_req), 8'(e_restart));
        chk("sleep_ok", 8'(sleep_ok), 8'(e_ok));
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("switch", 8'(sw), 8'h00);
        rd(hvm_pkg::REG_MEAS_CTRL, 8'h00, "enable");
        rd(hvm_pkg::REG_WAKE_SRC, 8'h01, "wake src");
        rd(4'hF, 8'h00, "unmapped");
    endtask
    task automatic t_enable_modes();
        wr(hvm_pkg::REG_PULL_CFG, 8'h02);
        chk("pull on", 8'(sense_pull), 8'h02);
        wr(hvm_pkg::REG_MEAS_CTRL, 8'h01);
        chk("switch", 8'(sw), 8'h01);
        chk("pulls", 8'({sense_pull, aux_pull}), 8'h00);
        repeat (2) @(posedge core_clk);
        #1 chk("adc", 8'(adc), 8'(sense));
        @(posedge core_clk);
        #1 chk("adc", 8'(adc), 8'(sense));
        for (int m = 0; m < 6; m++) begin
            @(posedge core_clk) op_mode <= hvm_pkg::hvm_mode_t'(m);
            @(posedge core_clk);
            #1 chk("mode switch", 8'(sw), 8'(m == 1));
            rd(hvm_pkg::REG_STATUS, 8'h02 | 8'(m == 1), "status");
        end
        @(posedge core_clk) op_mode <= hvm_pkg::MODE_NORMAL;
    endtask
    task automatic t_settings();
        wr(hvm_pkg::REG_PULL_CFG, 8'h01);
        wr(hvm_pkg::REG_WAKE_SRC, 8'h03);
        chk("pulls", 8'({sense_pull, aux_pull}), 8'h00);
        rd(hvm_pkg::REG_PULL_CFG, 8'h01, "pull cfg");
        rd(hvm_pkg::REG_WAKE_SRC, 8'h03, "wake src");
        @(posedge core_clk) sense <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1 chk("wake", 8'(wake_event), 8'h00);
        rd(hvm_pkg::REG_WAKE_STAT_A, 8'h00, "stat a");
        wr(hvm_pkg::REG_WAKE_SRC, 8'h01);
    endtask
    task automatic t_sleep();
        sleep_try(1'b1, 1'b0);
        rd(hvm_pkg::REG_FAULT, 8'h01, "fault");
        wr(hvm_pkg::REG_FAULT, 8'h01);
        wr(hvm_pkg::REG_WAKE_SRC, 8'h05);
        sleep_try(1'b0, 1'b1);
        rd(hvm_pkg::REG_FAULT, 8'h00, "fault");
    endtask
    task automatic t_aux();
        wr(hvm_pkg::REG_FAIL_TEST, 8'h01);
        wr(hvm_pkg::REG_AUX_CFG, 8'h01);
        chk("aux oe", 8'(aux_oe), 8'h00);
        rd(hvm_pkg::REG_FAULT, 8'h01, "fault");
        wr(hvm_pkg::REG_MEAS_CTRL, 8'h00);
        chk("aux oe", 8'(aux_oe), 8'h01);
        wr(hvm_pkg::REG_FAULT, 8'h01);
        wr(hvm_pkg::REG_MEAS_CTRL, 8'h01);
        chk("switch", 8'(sw), 8'h00);
        rd(hvm_pkg::REG_MEAS_CTRL, 8'h00, "enable");
        rd(hvm_pkg::REG_FAULT, 8'h01, "fault");
    endtask
    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        {rst_b, reg_wr, reg_rd, sleep_cmd, fail_active, sense} = '0;
        {clk_en, reg_addr, reg_wdata} = {1'b1, 12'h000};
        op_mode = hvm_pkg::MODE_NORMAL;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_enable_modes();
        t_settings();
        t_sleep();
        t_aux();
        close_out();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        close_out();
    end
endmodule
